// >>> hw/ulw_load_right.sv
// right-part unaligned word load datapath with register port and interrupt
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps

// How it works
// RULE1: plain load adds sign-extended 16-bit offset
// RULE2: user variant adds sign-extended 9-bit offset
// RULE3: address is low byte; merge into right
// RULE4: byte/word select from address xor endianness
// RULE5: keep upper register bits, merge memory bits
// RULE6: merged word lands in low 32 bits
// RULE7: all four bytes loaded: sign-extend bit 31
// RULE8: otherwise keep upper or copy bit 31
// RULE9: right plus left load yields sign-extended word
// RULE10: user variant uses user mapping where kernel-mapped
// RULE11: user variant exists only if extension enabled
// RULE12: user variant needs coprocessor access, allowed segment
// RULE13: plain load raises only translation/bus/address/watch
// RULE14: sixth release omits left/right loads entirely
// RULE15: physical low bits xor reverse flag, clear if little
// RULE16: user variant adds reserved and unusable exceptions
// RULE17: single full writeback, only without exception
module ulw_load_right
  import ulw_pkg::*;
#(
  parameter int ARCH_RELEASE = 2,
  parameter int PADDR_W      = 36,
  parameter int REG_IDX_W    = 5
) (
  input  wire logic                   clk_sys,
  input  wire logic                   reset,
  // operation request from issue
  input  wire logic                   op_valid,
  output logic                        op_ready,
  input  wire logic                   load_word_right_user_op,
  input  wire logic [ULW_XLEN-1:0]    base_value,
  input  wire logic [ULW_IMM_W-1:0]   offset_imm,
  input  wire logic [REG_IDX_W-1:0]   dest_reg_index,
  input  wire logic [ULW_XLEN-1:0]    dest_value,
  input  wire logic                   cpu_big_endian_flag,
  input  wire logic                   memory_big_endian_flag,
  input  wire logic                   reversed_byte_order_flag,
  input  wire logic                   cop0_access_enabled,
  // address translation
  output logic                        xlat_valid,
  output logic [ULW_XLEN-1:0]         effective_byte_address,
  output logic                        xlat_user_mapping,
  input  wire logic                   xlat_done,
  input  wire logic [PADDR_W-1:0]     xlat_paddr,
  input  wire logic [1:0]             xlat_seg_mode,
  input  wire logic                   xlat_tlb_refill,
  input  wire logic                   xlat_tlb_invalid,
  input  wire logic                   xlat_addr_error,
  input  wire logic                   xlat_watch,
  // memory doubleword read
  output logic                        mem_valid,
  output logic [PADDR_W-1:0]          mem_paddr,
  input  wire logic                   mem_done,
  input  wire logic [ULW_XLEN-1:0]    mem_doubleword,
  input  wire logic                   mem_bus_error,
  // writeback and exception report
  output logic                        wb_valid,
  output logic [REG_IDX_W-1:0]        wb_index,
  output logic [ULW_XLEN-1:0]         wb_data,
  output logic                        exc_valid,
  output logic [2:0]                  exc_code,
  // register port
  input  wire logic [ULW_ADDR_W-1:0]  reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_write,
  input  wire logic                   reg_read,
  output logic [31:0]                 reg_rdata,
  output logic                        irq
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    ulw_state_type            state;
    logic                     user_op;
    logic [ULW_XLEN-1:0]      vaddr;
    logic [REG_IDX_W-1:0]     idx;
    logic [ULW_XLEN-1:0]      dest;
    logic                     be_cpu;
    logic                     be_mem;
    logic                     rev;
    logic [PADDR_W-1:0]       paddr;
    logic [1:0]               ctrl;
    logic [ULW_EV_W-1:0]      status;
    logic [ULW_EV_W-1:0]      mask;
    logic [2:0]               last_exc;
    logic [31:0]              rdata;
    logic                     wb_valid;
    logic [ULW_XLEN-1:0]      wb_data;
    logic                     exc_valid;
    logic [2:0]               exc_code;
  } ulw_regs_type;

  ulw_regs_type r;
  ulw_regs_type next_r;

  // ****************************************************************
  // merge datapath
  // ****************************************************************
  logic [1:0]             byte_sel;
  logic                   word_sel;
  logic [ULW_XLEN-1:0]    mem_shifted;
  logic [ULW_WORD_W-1:0]  byte_mask;
  logic [ULW_WORD_W-1:0]  merged_word;
  logic [ULW_WORD_W-1:0]  upper_fill;
  logic [ULW_XLEN-1:0]    merged_result;

  assign byte_sel = r.vaddr[1:0] ^ {2{r.be_cpu}};  // [RULE4]
  assign word_sel = r.vaddr[2] ^ r.be_cpu;         // [RULE4]

  always_comb begin
    // memory bits 31+32*word .. 32*word+8*byte land at bit 0 [RULE5]
    mem_shifted = mem_doubleword >>
                  {word_sel, 5'h00} >> {byte_sel, 3'h0};
    // the kept register bits are 31 .. 32-8*byte [RULE3]
    byte_mask   = 32'hFFFFFFFF >> {byte_sel, 3'h0};
    merged_word = (r.dest[ULW_WORD_W-1:0] & ~byte_mask) |
                  (mem_shifted[ULW_WORD_W-1:0] & byte_mask);  // [RULE5]
    if (byte_sel == 2'h0) begin
      // bit 31 came from memory; with the left load this completes
      // a properly sign-extended word whichever ran first [RULE7] [RULE9]
      upper_fill = {ULW_WORD_W{merged_word[ULW_WORD_W-1]}};
    end else if (r.ctrl[ULW_CTRL_FILL_SGN]) begin
      upper_fill = {ULW_WORD_W{r.dest[ULW_WORD_W-1]}};  // [RULE8]
    end else begin
      upper_fill = r.dest[ULW_XLEN-1:ULW_WORD_W];       // [RULE8]
    end
    merged_result = {upper_fill, merged_word};  // [RULE6]
  end

  // ****************************************************************
  // address forming
  // ****************************************************************
  logic [ULW_XLEN-1:0] offset_ext;
  logic [PADDR_W-1:0]  paddr_adj;

  always_comb begin
    if (load_word_right_user_op) begin
      offset_ext = {{(ULW_XLEN-ULW_USR_IMM_W){offset_imm[ULW_USR_IMM_W-1]}},
                    offset_imm[ULW_USR_IMM_W-1:0]};  // [RULE2]
    end else begin
      offset_ext = {{(ULW_XLEN-ULW_IMM_W){offset_imm[ULW_IMM_W-1]}},
                    offset_imm};                     // [RULE1]
    end
    paddr_adj = {xlat_paddr[PADDR_W-1:3],
                 xlat_paddr[2:0] ^ {3{r.rev}}};      // [RULE15]
    if (!r.be_mem) begin
      paddr_adj[2:0] = 3'h0;                         // [RULE15]
    end
  end

  // ****************************************************************
  // sequencing and register port
  // ****************************************************************
  logic seg_allowed;
  logic [ULW_EV_W-1:0] events;

  assign seg_allowed = (xlat_seg_mode != ULW_SEG_OTHER);

  always_comb begin
    next_r           = r;
    next_r.wb_valid  = 1'b0;
    next_r.exc_valid = 1'b0;
    next_r.rdata     = 32'h00000000;
    events           = ULW_EV_RESET;
    unique case (r.state)
      ULW_ST_IDLE: begin
        if (op_valid) begin
          next_r.user_op = load_word_right_user_op;
          next_r.vaddr   = base_value + offset_ext;  // [RULE1] [RULE2]
          next_r.idx     = dest_reg_index;
          next_r.dest    = dest_value;
          next_r.be_cpu  = cpu_big_endian_flag;
          next_r.be_mem  = memory_big_endian_flag;
          next_r.rev     = reversed_byte_order_flag;
          if (ARCH_RELEASE >= ULW_RELEASE_NO_LR) begin
            next_r.exc_code = ULW_EXC_RESERVED_OP;  // [RULE14]
            next_r.state    = ULW_ST_DONE;
          end else if (load_word_right_user_op &&
                       !r.ctrl[ULW_CTRL_USER_EXT]) begin
            next_r.exc_code = ULW_EXC_RESERVED_OP;  // [RULE11] [RULE16]
            next_r.state    = ULW_ST_DONE;
          end else if (load_word_right_user_op && !cop0_access_enabled) begin
            next_r.exc_code = ULW_EXC_COP_UNUSABLE; // [RULE12] [RULE16]
            next_r.state    = ULW_ST_DONE;
          end else begin
            next_r.exc_code = ULW_EXC_NONE;
            next_r.state    = ULW_ST_XLATE;
          end
        end
      end
      ULW_ST_XLATE: begin
        if (xlat_done) begin
          // priority among simultaneous faults is fixed here [RULE13]
          if (xlat_addr_error) begin
            next_r.exc_code = ULW_EXC_ADDR_ERROR;
          end else if (r.user_op && !seg_allowed) begin
            next_r.exc_code = ULW_EXC_ADDR_ERROR;   // [RULE12]
          end else if (xlat_tlb_refill) begin
            next_r.exc_code = ULW_EXC_TLB_REFILL;
          end else if (xlat_tlb_invalid) begin
            next_r.exc_code = ULW_EXC_TLB_INVALID;
          end else if (xlat_watch) begin
            next_r.exc_code = ULW_EXC_WATCH;
          end else begin
            next_r.exc_code = ULW_EXC_NONE;
          end
          next_r.paddr = paddr_adj;                 // [RULE15]
          if (xlat_addr_error || xlat_tlb_refill || xlat_tlb_invalid ||
              xlat_watch || (r.user_op && !seg_allowed)) begin
            next_r.state = ULW_ST_DONE;
          end else begin
            next_r.state = ULW_ST_MEM;
          end
        end
      end
      ULW_ST_MEM: begin
        if (mem_done) begin
          if (mem_bus_error) begin
            next_r.exc_code = ULW_EXC_BUS_ERROR;    // [RULE13]
          end else begin
            next_r.wb_data = merged_result;
          end
          next_r.state = ULW_ST_DONE;
        end
      end
      ULW_ST_DONE: begin
        // one writeback of all 64 bits, suppressed on any fault [RULE17]
        next_r.wb_valid  = (r.exc_code == ULW_EXC_NONE);
        next_r.exc_valid = (r.exc_code != ULW_EXC_NONE);
        next_r.last_exc  = r.exc_code;
        events[ULW_EV_DONE] = 1'b1;
        events[ULW_EV_EXC]  = (r.exc_code != ULW_EXC_NONE);
        next_r.state     = ULW_ST_IDLE;
      end
    endcase

    // software writes; a clearing write never loses a same-cycle event
    if (reg_write && reg_addr == ULW_REG_CTRL) begin
      next_r.ctrl = reg_wdata[1:0];
    end
    if (reg_write && reg_addr == ULW_REG_MASK) begin
      next_r.mask = reg_wdata[ULW_EV_W-1:0];
    end
    if (reg_write && reg_addr == ULW_REG_STATUS) begin
      next_r.status = r.status & ~reg_wdata[ULW_EV_W-1:0];
    end
    next_r.status = next_r.status | events;

    if (reg_read) begin
      unique case (reg_addr)
        ULW_REG_CTRL:   next_r.rdata = {30'h00000000, r.ctrl};
        ULW_REG_STATUS: next_r.rdata = {30'h00000000, r.status};
        ULW_REG_MASK:   next_r.rdata = {30'h00000000, r.mask};
        ULW_REG_EXC:    next_r.rdata = {29'h00000000, r.last_exc};
        default:        next_r.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      r.state     <= ULW_ST_IDLE;
      r.user_op   <= 1'b0;
      r.vaddr     <= '0;
      r.idx       <= '0;
      r.dest      <= '0;
      r.be_cpu    <= 1'b0;
      r.be_mem    <= 1'b0;
      r.rev       <= 1'b0;
      r.paddr     <= '0;
      r.ctrl      <= ULW_CTRL_RESET;
      r.status    <= ULW_EV_RESET;
      r.mask      <= ULW_EV_RESET;
      r.last_exc  <= ULW_EXC_NONE;
      r.rdata     <= 32'h00000000;
      r.wb_valid  <= 1'b0;
      r.wb_data   <= '0;
      r.exc_valid <= 1'b0;
      r.exc_code  <= ULW_EXC_NONE;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign op_ready               = (r.state == ULW_ST_IDLE);
  assign xlat_valid             = (r.state == ULW_ST_XLATE);
  assign effective_byte_address = r.vaddr;
  // user mapping only matters inside kernel-mapped user segments [RULE10]
  assign xlat_user_mapping      = r.user_op;
  assign mem_valid              = (r.state == ULW_ST_MEM);
  assign mem_paddr              = r.paddr;
  assign wb_valid               = r.wb_valid;
  assign wb_index               = r.idx;
  assign wb_data                = r.wb_data;
  assign exc_valid              = r.exc_valid;
  assign exc_code               = r.exc_code;
  assign reg_rdata              = r.rdata;
  assign irq                    = |(r.status & r.mask);

endmodule

// >>> hw/ulw_pkg.sv
// shared constants and types for the right-part unaligned word load unit
package ulw_pkg;

  // ****************************************************************
  // datapath widths
  // ****************************************************************
  localparam int ULW_XLEN      = 64;
  localparam int ULW_WORD_W    = 32;
  localparam int ULW_IMM_W     = 16;
  localparam int ULW_USR_IMM_W = 9;
  localparam int ULW_BYTE_W    = 8;

  // ****************************************************************
  // register map (byte addresses on the plain register port)
  // ****************************************************************
  localparam int ULW_ADDR_W = 4;
  localparam logic [3:0] ULW_REG_CTRL   = 4'h0;
  localparam logic [3:0] ULW_REG_STATUS = 4'h4;
  localparam logic [3:0] ULW_REG_MASK   = 4'h8;
  localparam logic [3:0] ULW_REG_EXC    = 4'hC;

  // control fields
  localparam int ULW_CTRL_USER_EXT = 0;
  localparam int ULW_CTRL_FILL_SGN = 1;
  localparam logic [1:0] ULW_CTRL_RESET = 2'h0;

  // status / mask fields
  localparam int ULW_EV_W    = 2;
  localparam int ULW_EV_DONE = 0;
  localparam int ULW_EV_EXC  = 1;
  localparam logic [1:0] ULW_EV_RESET = 2'h0;

  // release at which the left/right family is removed
  localparam int ULW_RELEASE_NO_LR = 6;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    ULW_SEG_KERNEL_USER_MAPPED = 2'h0,
    ULW_SEG_UNMAPPED_USER      = 2'h1,
    ULW_SEG_MAPPED_USER        = 2'h2,
    ULW_SEG_OTHER              = 2'h3
  } ulw_seg_mode_type;

  typedef enum logic [2:0] {
    ULW_EXC_NONE         = 3'h0,
    ULW_EXC_TLB_REFILL   = 3'h1,
    ULW_EXC_TLB_INVALID  = 3'h2,
    ULW_EXC_BUS_ERROR    = 3'h3,
    ULW_EXC_ADDR_ERROR   = 3'h4,
    ULW_EXC_WATCH        = 3'h5,
    ULW_EXC_RESERVED_OP  = 3'h6,
    ULW_EXC_COP_UNUSABLE = 3'h7
  } ulw_exc_type;

  typedef enum {
    ULW_ST_IDLE,
    ULW_ST_XLATE,
    ULW_ST_MEM,
    ULW_ST_DONE
  } ulw_state_type;

endpackage

// >>> dv/ulw_props.sv
// assertion checker for the right-part unaligned word load unit
`timescale 1ns/1ps
module ulw_props (
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        op_valid,
  input wire logic        op_ready,
  input wire logic        load_word_right_user_op,
  input wire logic [63:0] base_value,
  input wire logic [15:0] offset_imm,
  input wire logic        xlat_valid,
  input wire logic [63:0] effective_byte_address,
  input wire logic        xlat_user_mapping,
  input wire logic        xlat_done,
  input wire logic [1:0]  xlat_seg_mode,
  input wire logic        xlat_tlb_refill,
  input wire logic        xlat_addr_error,
  input wire logic        mem_valid,
  input wire logic        mem_done,
  input wire logic        mem_bus_error,
  input wire logic        wb_valid,
  input wire logic        exc_valid,
  input wire logic [2:0]  exc_code
);
  logic [63:0] sx16, sx9;
  logic        p_take, u_take;
  assign sx16 = base_value + {{48{offset_imm[15]}}, offset_imm};
  assign sx9 = base_value + {{55{offset_imm[8]}}, offset_imm[8:0]};
  assign p_take = op_valid && op_ready && !load_word_right_user_op;
  assign u_take = op_valid && op_ready && load_word_right_user_op;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // ****************************************************************
  // properties
  // ****************************************************************
  property p_eff_plain;
    p_take ##1 xlat_valid |-> effective_byte_address == $past(sx16);
  endproperty
  a_eff_plain: assert property (p_eff_plain)
    else $error("plain addr");
  property p_eff_user;
    u_take ##1 xlat_valid |-> effective_byte_address == $past(sx9);
  endproperty
  a_eff_user: assert property (p_eff_user)
    else $error("user addr");
  property p_user_map;
    u_take ##1 xlat_valid |-> xlat_user_mapping;
  endproperty
  a_user_map: assert property (p_user_map)
    else $error("user map");
  property p_xlat_hold;
    xlat_valid && !xlat_done |=> xlat_valid && $stable(effective_byte_address);
  endproperty
  a_xlat_hold: assert property (p_xlat_hold)
    else $error("xlat hold");
  property p_mem_wb;
    mem_valid && mem_done && !mem_bus_error |-> ##2 wb_valid && !exc_valid;
  endproperty
  a_mem_wb: assert property (p_mem_wb)
    else $error("no writeback");
  property p_bus;
    mem_valid && mem_done && mem_bus_error |->
      ##2 exc_valid && exc_code == 3'h3;
  endproperty
  a_bus: assert property (p_bus)
    else $error("bus error code");
  property p_refill;
    xlat_valid && xlat_done && xlat_tlb_refill && !xlat_addr_error &&
      xlat_seg_mode != 2'h3 |-> ##2 exc_valid && exc_code == 3'h1;
  endproperty
  a_refill: assert property (p_refill)
    else $error("refill code");
  // a reported fault must carry a real code and never a writeback
  property p_wb_excl;
    exc_valid |-> !wb_valid && exc_code != 3'h0;
  endproperty
  a_wb_excl: assert property (p_wb_excl)
    else $error("wb with exc");
endmodule

// >>> dv/ulw_far_model.sv
// far-side model: translator and doubleword memory with settable latency
`timescale 1ns/1ps
module ulw_far_model #(
  parameter logic [63:0] MEM_DW = 64'h0
) (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic [3:0]  lat,
  input  wire logic [1:0]  seg,
  input  wire logic        f_rfl,
  input  wire logic        f_berr,
  input  wire logic        xlat_valid,
  input  wire logic [63:0] effective_byte_address,
  input  wire logic        mem_valid,
  input  wire logic [35:0] mem_paddr,
  output logic             xlat_done,
  output logic [35:0]      xlat_paddr,
  output logic [1:0]       xlat_seg_mode,
  output logic             xlat_tlb_refill,
  output logic             mem_done,
  output logic [63:0]      mem_doubleword,
  output logic             mem_bus_error,
  output logic [35:0]      seen
);
  logic [3:0] cnt;
  always @(posedge clk_sys) begin
    xlat_done <= 1'b0;
    mem_done <= 1'b0;
    if (reset)
      cnt <= 4'h0;
    else if ((xlat_valid && !xlat_done) || (mem_valid && !mem_done)) begin
      cnt <= cnt + 4'h1;
      if (cnt == lat) begin
        cnt <= 4'h0;
        xlat_done <= xlat_valid;
        mem_done <= mem_valid;
        seen <= mem_paddr;
      end
    end
  end
  // released address, segment and data lines show the inverse so a stale sample never matches; fault flags read zero
  assign xlat_paddr = xlat_done ? effective_byte_address[35:0]
                                : ~effective_byte_address[35:0];
  assign xlat_seg_mode = xlat_done ? seg : ~seg;
  assign xlat_tlb_refill = xlat_done & f_rfl;
  assign mem_doubleword = mem_done ? MEM_DW : ~MEM_DW;
  assign mem_bus_error = mem_done & f_berr;
endmodule

// >>> dv/test_ulw_load_right.sv
// self-checking bench for the right-part unaligned word load unit
`timescale 1ns/1ps
module test_ulw_load_right;
  import ulw_pkg::*;
  localparam logic [63:0] MEM = 64'hF7E6D5C4B3A29180;
  localparam logic [63:0] D1 = 64'hA1B2C3D4E5F60718;
  logic        clk_sys = 1'b0, reset = 1'b1, op_valid = 1'b0, op_ready;
  logic        load_word_right_user_op = 1'b0, cop0_access_enabled = 1'b1;
  logic        cpu_big_endian_flag = 1'b0, memory_big_endian_flag = 1'b1;
  logic        reversed_byte_order_flag = 1'b0, f_rfl = 1'b0, f_berr = 1'b0;
  logic        xlat_tlb_invalid = 1'b0, xlat_addr_error = 1'b0;
  logic        xlat_watch = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
  logic        xlat_valid, xlat_user_mapping, xlat_done, xlat_tlb_refill;
  logic        mem_valid, mem_done, mem_bus_error, wb_valid, exc_valid, irq;
  logic [63:0] base_value = 64'h1000, dest_value = 64'h0;
  logic [63:0] effective_byte_address, mem_doubleword, wb_data;
  logic [15:0] offset_imm = 16'h0;
  logic [4:0]  dest_reg_index = 5'h13, wb_index;
  logic [35:0] xlat_paddr, mem_paddr, seen;
  logic [1:0]  xlat_seg_mode, seg = 2'h0;
  logic [2:0]  exc_code;
  logic [3:0]  reg_addr = 4'h0, lat = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  int          failures = 0, compares = 0, cycles = 0;

  ulw_load_right u_ulw_load_right (.*);
  ulw_far_model #(.MEM_DW(MEM)) u_ulw_far_model (.*);

  initial forever #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      end_sim;
    end
  end
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic check(input string nm, input logic [63:0] s, e);
    compares++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task end_sim;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_write <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1;
    check("reg_rdata", 64'(reg_rdata), 64'(e));
  endtask
  function automatic logic [63:0] exp_wb(input logic [63:0] d,
      input logic [2:0] va, input logic be, fl);
    logic [1:0]  b;
    logic [31:0] m, k, lo;
    b = va[1:0] ^ {2{be}};
    m = (va[2] ^ be) ? MEM[63:32] : MEM[31:0];
    k = 32'hFFFFFFFF >> (8 * b);
    lo = (d[31:0] & ~k) | ((m >> (8 * b)) & k);
    if (b == 2'h0)
      return {{32{lo[31]}}, lo};
    return {fl ? {32{d[31]}} : d[63:32], lo};
  endfunction
  task automatic load(input logic u, input logic [15:0] o,
      input logic [63:0] d, e, input logic [2:0] c);
    int n = 0;
    @(posedge clk_sys);
    op_valid <= 1'b1;
    load_word_right_user_op <= u;
    offset_imm <= o;
    dest_value <= d;
    @(posedge clk_sys);
    op_valid <= 1'b0;
    while (wb_valid !== 1'b1 && exc_valid !== 1'b1 && n < 40) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (c == 3'h0) begin
      check("wb_valid", 64'(wb_valid), 64'h1);
      check("wb_data", wb_data, e);
      check("wb_index", 64'(wb_index), 64'h13);
    end else begin
      check("exc_valid", 64'(exc_valid), 64'h1);
      check("exc_code", 64'(exc_code), 64'(c));
      check("wb_valid", 64'(wb_valid), 64'h0);
    end
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task t_regs;
    rd(ULW_REG_CTRL, 32'h0);
    rd(ULW_REG_STATUS, 32'h0);
    rd(ULW_REG_EXC, 32'h0);
    rd(4'h2, 32'h0);
    wr(ULW_REG_MASK, 32'h3);
    rd(ULW_REG_MASK, 32'h3);
    $display("t_regs done");
  endtask
  task t_merge;
    logic [63:0] d;
    for (int p = 0; p < 2; p++) begin
      wr(ULW_REG_CTRL, {30'h0, p[0], 1'b0});
      for (int i = 0; i < 16; i++) begin
        d = i[0] ? 64'h1122334455667788 : D1;
        cpu_big_endian_flag <= i[3];
        reversed_byte_order_flag <= i[1];
        memory_big_endian_flag <= i[0];
        load(1'b0, {13'h1FFE, i[2:0]}, d, exp_wb(d, i[2:0], i[3], p[0]),
             3'h0);
        check("mem_paddr", 64'(seen[2:0]),
              64'(i[0] ? i[2:0] ^ {3{i[1]}} : 3'h0));
      end
    end
    $display("t_merge done");
  endtask
  task t_user;
    cpu_big_endian_flag <= 1'b0;
    wr(ULW_REG_CTRL, 32'h0);
    load(1'b1, 16'h01F8, D1, 64'h0, 3'h6);
    wr(ULW_REG_CTRL, 32'h1);
    cop0_access_enabled <= 1'b0;
    load(1'b1, 16'h01F8, D1, 64'h0, 3'h7);
    cop0_access_enabled <= 1'b1;
    seg <= 2'h3;
    load(1'b1, 16'h01F8, D1, 64'h0, 3'h4);
    for (int s = 0; s < 3; s++) begin
      seg <= s[1:0];
      load(1'b1, 16'h01F8, D1, exp_wb(D1, 3'h0, 1'b0, 1'b0),
           3'h0);
    end
    $display("t_user done");
  endtask
  task t_faults;
    wr(ULW_REG_STATUS, 32'h3);
    wr(ULW_REG_MASK, 32'h2);
    check("irq", 64'(irq), 64'h0);
    lat <= 4'h3;
    f_rfl <= 1'b1;
    load(1'b0, 16'h0, D1, 64'h0, 3'h1);
    check("irq", 64'(irq), 64'h1);
    rd(ULW_REG_EXC, 32'h1);
    wr(ULW_REG_STATUS, 32'h3);
    check("irq", 64'(irq), 64'h0);
    f_rfl <= 1'b0;
    f_berr <= 1'b1;
    load(1'b0, 16'h0, D1, 64'h0, 3'h3);
    f_berr <= 1'b0;
    xlat_tlb_invalid <= 1'b1;
    load(1'b0, 16'h0, D1, 64'h0, 3'h2);
    xlat_tlb_invalid <= 1'b0;
    xlat_watch <= 1'b1;
    load(1'b0, 16'h0, D1, 64'h0, 3'h5);
    // address error outranks a watch hit in the same translation
    xlat_addr_error <= 1'b1;
    load(1'b0, 16'h0, D1, 64'h0, 3'h4);
    xlat_watch <= 1'b0;
    xlat_addr_error <= 1'b0;
    load(1'b0, 16'h0, D1, exp_wb(D1, 3'h0, 1'b0, 1'b0), 3'h0);
    rd(ULW_REG_STATUS, 32'h3);
    $display("t_faults done");
  endtask
  task t_reset;
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    #1;
    check("irq", 64'(irq), 64'h0);
    rd(ULW_REG_STATUS, 32'h0);
    rd(ULW_REG_CTRL, 32'h0);
    load(1'b0, 16'h0, D1, exp_wb(D1, 3'h0, 1'b0, 1'b0), 3'h0);
    $display("t_reset done");
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    t_regs;
    t_merge;
    t_user;
    t_faults;
    t_reset;
    end_sim;
  end
endmodule

bind ulw_load_right ulw_props u_ulw_props (.*);
